// >>> design/jcp_flash.sv
// Flash array with its program and erase engine.
`timescale 1ns/100ps
`default_nettype none
module jcp_flash import jcp_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	jcp_flash_if.eng f
);
	localparam int ERASE_N = ERASE_CYC;
	logic [DW-1:0]    mem [2**AW];
	jcp_fst_t         state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [AW-1:0]    addr, next_addr;
	logic [DW-1:0]    data, next_data;
	logic             bad, next_bad;
	logic             fin;

	function automatic logic [2:0] sect(input logic [AW-1:0] a);
		return a[AW-1:SECT_LSB];
	endfunction

	// ----------------------------------------
	// Cycle sequencing; reset abort wins over everything.
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt + 1'b1;
		next_addr = addr;
		next_data = data;
		next_bad = bad;
		fin = 1'b0;
		if (f.abort) begin
			next_state = FS_READ;
			next_cnt = '0;
		end else begin
			unique case (state)
				FS_READ: begin
					next_cnt = '0;
					if (f.req) begin
						next_addr = f.addr;
						next_data = f.wdata;
						unique case (f.op)
							FOP_PROG: begin
								next_state = FS_PROG;
								next_bad = (mem[f.addr] & f.wdata) != f.wdata;
							end
							FOP_ERASE: begin
								next_state = FS_ERASE;
								next_bad = f.protect[sect(f.addr)];
							end
							default: begin
								next_state = FS_CHIP;
								next_bad = 1'b0;
							end
						endcase
					end
				end
				FS_PROG: fin = cnt == CNT_W'(PROG_CYC - 1);
				FS_ERASE, FS_CHIP: fin = cnt == CNT_W'(ERASE_CYC - 1);
			endcase
			if (fin) begin
				next_state = FS_READ;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FS_READ;
			cnt <= '0;
			addr <= '0;
			data <= BLANK_BYTE;
			bad <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			addr <= next_addr;
			data <= next_data;
			bad <= next_bad;
		end
	end

	// Array starts blank; a failed program still pulls bits low, as real cells do.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2**AW; i++) mem[i] <= BLANK_BYTE;
		end else if (fin) begin
			for (int i = 0; i < 2**AW; i++) begin
				if (state == FS_CHIP) begin
					mem[i] <= BLANK_BYTE;
				end else if (state == FS_ERASE && !bad && sect(AW'(i)) == sect(addr)) begin
					mem[i] <= BLANK_BYTE;
				end else if (state == FS_PROG && AW'(i) == addr) begin
					mem[i] <= mem[i] & data;
				end
			end
		end
	end

	assign f.busy = state != FS_READ;
	assign f.done = fin;
	assign f.fail = fin & bad;
	assign f.rdata = mem[f.addr];

	a_prog_busy: assert property (@(posedge clk) disable iff (!rst_n || f.abort)
		state == FS_READ && f.req && f.op == FOP_PROG |=> f.busy [*8])
		else $error("program cycle did not hold busy");
	a_prot_fail: assert property (@(posedge clk) disable iff (!rst_n || f.abort)
		state == FS_READ && f.req && f.op == FOP_ERASE && f.protect[sect(f.addr)]
		|-> ##ERASE_N f.fail)
		else $error("protected sector erase did not fail");
endmodule // jcp_flash
`default_nettype wire

// >>> design/jcp_flash_if.sv
// Request and answer signals between the port logic and the flash engine.
`timescale 1ns/100ps
`default_nettype none
interface jcp_flash_if;
	import jcp_pkg::*;
	logic             req;
	jcp_fop_t         op;
	logic [AW-1:0]    addr;
	logic [DW-1:0]    wdata;
	logic             abort;
	logic [NSECT-1:0] protect;
	logic             busy;
	logic             done;
	logic             fail;
	logic [DW-1:0]    rdata;
	modport ctl (output req, op, addr, wdata, abort, protect,
		input busy, done, fail, rdata);
	modport eng (input req, op, addr, wdata, abort, protect,
		output busy, done, fail, rdata);
endinterface
`default_nettype wire

// >>> design/jcp_pkg.sv
// Shared constants and types for the test-port configuration block.
package jcp_pkg;
	localparam int IR_W = 4;
	localparam int DR_W = 16;
	localparam int AW = 7;
	localparam int DW = 8;
	localparam int NSECT = 8;
	localparam int SECT_LSB = 4;
	localparam int ADDR_LSB = 8;
	localparam int CNT_W = 12;
	localparam int EN_PINS_BIT = 0;
	localparam int OD_BIT = 1;
	localparam int CLK_NS = 10;
	localparam int T_PROG_NS = 2000;
	localparam int T_ERASE_NS = 2500;
	localparam int T_ABORT_NS = 30;
	localparam int PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ABORT_CYC = (T_ABORT_NS < CLK_NS) ? 1 : T_ABORT_NS / CLK_NS;
	localparam logic [DW-1:0] BLANK_BYTE = 8'hff;
	localparam logic [NSECT-1:0] PROT_RST = 8'h00;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	typedef enum logic [IR_W-1:0] {
		ISC_ENABLE = 4'h1, ISC_DISABLE = 4'h2, ISC_PROGRAM = 4'h3,
		ISC_ERASE = 4'h4, ISC_CHIP_ERASE = 4'h5, ISC_READ = 4'h6,
		ISC_CLEAR = 4'h7, ISC_SECURE = 4'h8, ISC_PROTECT = 4'h9,
		ISC_STATUS = 4'ha, ISC_BYPASS = 4'hf
	} jcp_ir_t;
	typedef enum logic [1:0] {
		FOP_PROG = 2'b00, FOP_ERASE = 2'b01, FOP_CHIP = 2'b10
	} jcp_fop_t;
	typedef enum logic [1:0] {
		FS_READ = 2'b00, FS_PROG = 2'b01, FS_ERASE = 2'b10, FS_CHIP = 2'b11
	} jcp_fst_t;
	typedef enum logic [3:0] {
		TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
		SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
		UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
		EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
	} jcp_tap_t;
endpackage

// >>> design/jcp_tap.sv
// Test access port state machine stepped by sampled test-clock edges.
`timescale 1ns/100ps
`default_nettype none
module jcp_tap import jcp_pkg::*; (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic step,
	input  wire logic tms,
	output var jcp_tap_t state
);
	jcp_tap_t next_state;

	// ----------------------------------------
	// Standard sixteen-state walk on each step.
	// ----------------------------------------
	always_comb begin
		next_state = state;
		if (step) begin
			unique case (state)
				TLR:    next_state = tms ? TLR : RTI;
				RTI:    next_state = tms ? SEL_DR : RTI;
				SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
				CAP_DR: next_state = tms ? EX1_DR : SH_DR;
				SH_DR:  next_state = tms ? EX1_DR : SH_DR;
				EX1_DR: next_state = tms ? UPD_DR : PA_DR;
				PA_DR:  next_state = tms ? EX2_DR : PA_DR;
				EX2_DR: next_state = tms ? UPD_DR : SH_DR;
				UPD_DR: next_state = tms ? SEL_DR : RTI;
				SEL_IR: next_state = tms ? TLR : CAP_IR;
				CAP_IR: next_state = tms ? EX1_IR : SH_IR;
				SH_IR:  next_state = tms ? EX1_IR : SH_IR;
				EX1_IR: next_state = tms ? UPD_IR : PA_IR;
				PA_IR:  next_state = tms ? EX2_IR : PA_IR;
				EX2_IR: next_state = tms ? UPD_IR : SH_IR;
				UPD_IR: next_state = tms ? SEL_DR : RTI;
			endcase
		end
	end

	// Five high mode samples always bring it home, so no extra reset pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= TLR;
		end else begin
			state <= next_state;
		end
	end
endmodule // jcp_tap
`default_nettype wire

// >>> design/jcp_top.sv
// In-system configuration port: test-port front end, command decode and pins.
// Notes on behaviour
// - Reset pulse returns flash engine to idle.
// - Reset aborts running cycle within bounded time.
// - All arrays and configuration programmable through port.
// - Blank device: four pins are test port.
// - Data out undriven until enabling command.
// - Enable command optionally activates status pins.
// - Configuration commands only, no boundary scan.
// - Error pin low until clear, or a device reset pulse after disable.
// - Status pin high in read mode only.
// - Enable command can select open-drain pins.
// - Secured device refuses program, erase, read and protect; chip erase still runs.
// - Chip erase clears security, leaves device blank.
// - Per-sector protect bit blocks sector erase.
// - Blank device reads all ones.
`timescale 1ns/100ps
`default_nettype none
module jcp_top import jcp_pkg::*; (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	output var  logic tdo,
	output var  logic tdo_oe_n,
	input  wire logic dev_rst_n,
	input  wire logic gp_stat_out,
	input  wire logic gp_stat_oe_n,
	input  wire logic gp_err_out,
	input  wire logic gp_err_oe_n,
	output var  logic prog_status_pin,
	output var  logic prog_status_oe_n,
	output var  logic prog_error_pin,
	output var  logic prog_error_oe_n,
	output var  logic isc_active,
	output var  logic secure_lock
);
	localparam int ABORT_N = ABORT_CYC;

	// ----------------------------------------
	// Reset release and pin synchronisers.
	// ----------------------------------------
	logic [1:0] rs;
	logic       rst_n;
	logic [3:0] pin_s1, pin_s2;
	logic       tck_d, dev_d;

	// Release is synchronous so no flop sees reset leave mid-edge.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs <= 2'b00;
		end else begin
			rs <= {rs[0], 1'b1};
		end
	end
	assign rst_n = rs[1];

	// Test clock is only sampled; its edges come from the second stage.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 4'h8;
			pin_s2 <= 4'h8;
			tck_d <= 1'b0;
			dev_d <= 1'b1;
		end else begin
			pin_s1 <= {dev_rst_n, tdi, tms, tck};
			pin_s2 <= pin_s1;
			tck_d <= pin_s2[0];
			dev_d <= pin_s2[3];
		end
	end

	logic tck_rise, tck_fall, dev_s, dev_rel;
	assign tck_rise = pin_s2[0] & ~tck_d;
	assign tck_fall = ~pin_s2[0] & tck_d;
	assign dev_s = pin_s2[3];
	assign dev_rel = dev_s & ~dev_d;

	// ----------------------------------------
	// Sub-blocks.
	// ----------------------------------------
	jcp_tap_t    tap;
	jcp_flash_if f ();

	jcp_tap u_tap (
		.clk   (clk),
		.rst_n (rst_n),
		.step  (tck_rise),
		.tms   (pin_s2[1]),
		.state (tap)
	);

	jcp_flash u_flash (
		.clk   (clk),
		.rst_n (rst_n),
		.f     (f)
	);

	// Only codes the decoder handles are accepted; the rest fall to bypass.
	function automatic logic known(input logic [IR_W-1:0] c);
		return c inside {ISC_ENABLE, ISC_DISABLE, ISC_PROGRAM, ISC_ERASE,
			ISC_CHIP_ERASE, ISC_READ, ISC_CLEAR, ISC_SECURE, ISC_PROTECT,
			ISC_STATUS, ISC_BYPASS};
	endfunction

	// ----------------------------------------
	// Port state, command effects and pins.
	// ----------------------------------------
	jcp_ir_t          ir, next_ir;
	logic [IR_W-1:0]  ir_sh, next_ir_sh;
	logic [DR_W-1:0]  dr_sh, next_dr_sh;
	logic             byp, next_byp;
	logic             next_tdo, next_tdo_oe_n;
	logic             ext_en, next_ext_en;
	logic             od, next_od;
	logic             dis_seen, next_dis_seen;
	logic             err, next_err;
	logic [NSECT-1:0] protect, next_protect;
	logic             req, next_req;
	jcp_fop_t         op, next_op;
	logic [AW-1:0]    addr, next_addr;
	logic [DW-1:0]    wdata, next_wdata;
	logic             next_isc_active, next_secure_lock;
	logic             next_ps_pin, next_ps_oe_n;
	logic             next_pe_pin, next_pe_oe_n;
	logic             upd, blocked, rdy_val, er_val;

	// Only the arrival of reset aborts, so a reset held for a whole session still programs.
	assign f.req = req;
	assign f.op = op;
	assign f.addr = addr;
	assign f.wdata = wdata;
	assign f.protect = protect;
	assign f.abort = ~dev_s & dev_d;

	always_comb begin
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_dr_sh = dr_sh;
		next_byp = byp;
		next_tdo = tdo;
		next_ext_en = ext_en;
		next_od = od;
		next_dis_seen = dis_seen;
		next_err = err;
		next_protect = protect;
		next_req = 1'b0;
		next_op = op;
		next_addr = addr;
		next_wdata = wdata;
		next_isc_active = isc_active;
		next_secure_lock = secure_lock;
		upd = tck_fall && tap == UPD_DR && isc_active;
		blocked = secure_lock || f.busy || req;
		// Capture and shift act on the rising test clock.
		if (tck_rise) begin
			unique case (tap)
				CAP_IR: next_ir_sh = IR_CAPTURE;
				SH_IR: next_ir_sh = {pin_s2[2], ir_sh[IR_W-1:1]};
				CAP_DR: begin
					next_byp = 1'b0;
					if (ir == ISC_STATUS) begin
						next_dr_sh = DR_W'({secure_lock, err, f.busy});
					end else if (ir == ISC_READ && !secure_lock) begin
						next_dr_sh = {1'b0, addr, f.rdata};
					end else begin
						next_dr_sh = '0;
					end
				end
				SH_DR: begin
					next_byp = pin_s2[2];
					next_dr_sh = {pin_s2[2], dr_sh[DR_W-1:1]};
				end
				default: begin
				end
			endcase
		end
		// Data out changes on the falling test clock, inside shift states.
		if (tck_fall && tap == SH_IR) begin
			next_tdo = ir_sh[0];
		end else if (tck_fall && tap == SH_DR) begin
			next_tdo = (ir == ISC_BYPASS) ? byp : dr_sh[0];
		end
		if (tck_fall && tap == UPD_IR) begin
			next_ir = known(ir_sh) ? jcp_ir_t'(ir_sh) : ISC_BYPASS;
		end else if (tap == TLR) begin
			next_ir = ISC_BYPASS;
		end
		// Enable opens the channel; its data picks the pin options.
		if (tck_fall && tap == UPD_DR && ir == ISC_ENABLE) begin
			next_isc_active = 1'b1;
			next_ext_en = dr_sh[EN_PINS_BIT];
			next_od = dr_sh[OD_BIT];
		end
		if (upd) begin
			unique case (ir)
				ISC_DISABLE: begin
					next_isc_active = 1'b0;
					next_ext_en = 1'b0;
					next_dis_seen = 1'b1;
				end
				ISC_PROGRAM, ISC_ERASE: begin
					if (!blocked) begin
						next_req = 1'b1;
						next_op = (ir == ISC_PROGRAM) ? FOP_PROG : FOP_ERASE;
						next_addr = dr_sh[ADDR_LSB +: AW];
						next_wdata = dr_sh[DW-1:0];
					end
				end
				ISC_CHIP_ERASE: begin
					if (!f.busy && !req) begin
						next_req = 1'b1;
						next_op = FOP_CHIP;
					end
				end
				ISC_READ: begin
					if (!secure_lock) begin
						next_addr = dr_sh[ADDR_LSB +: AW];
					end
				end
				ISC_SECURE: next_secure_lock = 1'b1;
				ISC_PROTECT: begin
					if (!secure_lock) begin
						next_protect = dr_sh[NSECT-1:0];
					end
				end
				ISC_CLEAR: next_err = 1'b0;
				default: begin
				end
			endcase
		end
		// A device reset pulse after disable also clears the error.
		if (dev_rel && dis_seen) begin
			next_err = 1'b0;
			next_dis_seen = 1'b0;
		end
		// A new failure in the clearing cycle is kept.
		if (f.fail) begin
			next_err = 1'b1;
		end
		if (f.done && op == FOP_CHIP) begin
			next_secure_lock = 1'b0;
			next_protect = PROT_RST;
		end
		next_tdo_oe_n = !(next_isc_active && (tap == SH_DR || tap == SH_IR));
		// Status follows busy, and also the pending request before busy rises.
		rdy_val = ~(f.busy | req);
		er_val = ~err;
		if (next_ext_en) begin
			next_ps_pin = next_od ? 1'b0 : rdy_val;
			next_ps_oe_n = next_od ? rdy_val : 1'b0;
			next_pe_pin = next_od ? 1'b0 : er_val;
			next_pe_oe_n = next_od ? er_val : 1'b0;
		end else begin
			next_ps_pin = gp_stat_out;
			next_ps_oe_n = gp_stat_oe_n;
			next_pe_pin = gp_err_out;
			next_pe_oe_n = gp_err_oe_n;
		end
	end

	// Power-up state: channel closed, pins on port duty, data out floating.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir <= ISC_BYPASS;
			ir_sh <= '0;
			dr_sh <= '0;
			byp <= 1'b0;
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
			ext_en <= 1'b0;
			od <= 1'b0;
			dis_seen <= 1'b0;
			err <= 1'b0;
			protect <= PROT_RST;
			req <= 1'b0;
			op <= FOP_PROG;
			addr <= '0;
			wdata <= BLANK_BYTE;
			isc_active <= 1'b0;
			secure_lock <= 1'b0;
			prog_status_pin <= 1'b0;
			prog_status_oe_n <= 1'b1;
			prog_error_pin <= 1'b0;
			prog_error_oe_n <= 1'b1;
		end else begin
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			dr_sh <= next_dr_sh;
			byp <= next_byp;
			tdo <= next_tdo;
			tdo_oe_n <= next_tdo_oe_n;
			ext_en <= next_ext_en;
			od <= next_od;
			dis_seen <= next_dis_seen;
			err <= next_err;
			protect <= next_protect;
			req <= next_req;
			op <= next_op;
			addr <= next_addr;
			wdata <= next_wdata;
			isc_active <= next_isc_active;
			secure_lock <= next_secure_lock;
			prog_status_pin <= next_ps_pin;
			prog_status_oe_n <= next_ps_oe_n;
			prog_error_pin <= next_pe_pin;
			prog_error_oe_n <= next_pe_oe_n;
		end
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	a_abort_idle: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(dev_s) |-> ##[1:ABORT_N] !f.busy)
		else $error("flash cycle not aborted by reset");
	a_tdo_closed: assert property (@(posedge clk) disable iff (!rst_n)
		!isc_active ##1 !isc_active |-> tdo_oe_n)
		else $error("data out driven while channel closed");
	a_secure_refuse: assert property (@(posedge clk) disable iff (!rst_n)
		secure_lock && req |-> op == FOP_CHIP)
		else $error("secured device took a refused command");
	a_chip_unlock: assert property (@(posedge clk) disable iff (!rst_n)
		f.done && op == FOP_CHIP |=> !secure_lock && protect == PROT_RST)
		else $error("chip erase left device secured");
	a_err_hold: assert property (@(posedge clk) disable iff (!rst_n)
		err && !(upd && ir == ISC_CLEAR) && !(dev_rel && dis_seen) |=> err)
		else $error("error flag dropped without clear");
	a_err_set: assert property (@(posedge clk) disable iff (!rst_n)
		f.fail ##1 ext_en && !od |=> !prog_error_pin)
		else $error("error pin not low after failure");
	a_status_pin: assert property (@(posedge clk) disable iff (!rst_n)
		ext_en && !od && f.busy |=> !prog_status_pin && !prog_status_oe_n)
		else $error("status pin not low during cycle");
	a_port_keep: assert property (@(posedge clk) disable iff (!rst_n)
		!next_ext_en |=> prog_error_oe_n == $past(gp_err_oe_n))
		else $error("error pin left port duty");
	a_ir_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		tck_fall && tap == UPD_IR && !known(ir_sh) |=> ir == ISC_BYPASS)
		else $error("unknown instruction not sent to bypass");
endmodule // jcp_top
`default_nettype wire

// >>> tb/jcp_ctl_model.sv
// Behavioural model of the external controller that drives the serial test pins.
`timescale 1ns/100ps
`default_nettype none
module jcp_ctl_model (
	input  wire logic clk,
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_n
);
	logic oe_seen;
	logic last;

	// The test clock rests low between frames, as a real cable leaves it.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		oe_seen = 1'b0;
		last = 1'b0;
	end

	// --------------------------------------------------------------
	// One test-clock period of 160 ns, changed only at falling clk.
	// --------------------------------------------------------------
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		repeat (8) @(negedge clk);
		tck = 1'b1;
		// A released data-out line is read as the inverse of its last level.
		o = tdo_oe_n ? ~last : tdo;
		last = o;
		if (!tdo_oe_n) oe_seen = 1'b1;
		repeat (8) @(negedge clk);
		tck = 1'b0;
	endtask

	// Walks idle to shift, moves n bits LSB first, then update and idle.
	task automatic scan(input logic ir, input int n, input logic [15:0] din,
		output logic [15:0] dout);
		logic o;
		dout = 16'h0000;
		tick(1'b1, 1'b0, o);
		if (ir) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask

	// Five high mode bits reach logic reset from any state, then idle.
	task automatic reset_tap();
		logic o;
		for (int i = 0; i < 5; i++) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
endmodule // jcp_ctl_model
`default_nettype wire

// >>> tb/jcp_top_tb_top.sv
// Self-checking testbench of the in-system configuration port.
`timescale 1ns/100ps
`default_nettype none
module jcp_top_tb_top import jcp_pkg::*; ;
	logic        clk, rstn, tck, tms, tdi, tdo, tdo_oe_n, dev_rst_n;
	logic        gp_stat_out, gp_stat_oe_n, gp_err_out, gp_err_oe_n;
	logic        prog_status_pin, prog_status_oe_n, prog_error_pin, prog_error_oe_n;
	logic        isc_active, secure_lock;
	logic [15:0] q;
	int          err_total = 0;
	int          n_tests = 0;

	jcp_top jcp_top_i (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n), .dev_rst_n(dev_rst_n),
		.gp_stat_out(gp_stat_out), .gp_stat_oe_n(gp_stat_oe_n),
		.gp_err_out(gp_err_out), .gp_err_oe_n(gp_err_oe_n),
		.prog_status_pin(prog_status_pin), .prog_status_oe_n(prog_status_oe_n),
		.prog_error_pin(prog_error_pin), .prog_error_oe_n(prog_error_oe_n),
		.isc_active(isc_active), .secure_lock(secure_lock));
	jcp_ctl_model jcp_ctl_model_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n));

	// --------------------------------------------------------------
	// Shared helpers
	// --------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Packs both extension pins as {status oe_n, status, error oe_n, error}.
	function automatic logic [15:0] pins();
		return {12'h000, prog_status_oe_n, prog_status_pin, prog_error_oe_n,
			prog_error_pin};
	endfunction

	task automatic ir(input logic [3:0] c);
		jcp_ctl_model_i.scan(1'b1, IR_W, {12'h000, c}, q);
	endtask
	task automatic dr(input logic [15:0] d);
		jcp_ctl_model_i.scan(1'b0, DR_W, d, q);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [15:0] d);
		ir(c);
		dr(d);
	endtask
	// Latch an address, then the next capture returns {0, addr, data}.
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		cmd(ISC_READ, {1'b0, a, 8'h00});
		dr(16'h0000);
		chk(q, exp);
	endtask
	// Polling bounds the wait; a stuck busy flag shows as a mismatch.
	task automatic wait_idle();
		ir(ISC_STATUS);
		for (int i = 0; i < 8; i++) begin
			dr(16'h0000);
			if (q[0] === 1'b0) break;
		end
		chk({15'h0000, q[0]}, 16'h0000);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_closed();
		chk(pins(), 16'h0006);
		// Port drive changes must pass straight through while the pins are not claimed.
		gp_stat_out = 1'b0;
		gp_stat_oe_n = 1'b1;
		gp_err_out = 1'b1;
		gp_err_oe_n = 1'b0;
		repeat (2) @(negedge clk);
		chk(pins(), 16'h0009);
		gp_stat_out = 1'b1;
		gp_stat_oe_n = 1'b0;
		gp_err_out = 1'b0;
		gp_err_oe_n = 1'b1;
		repeat (2) @(negedge clk);
		chk({13'h0000, tdo_oe_n, isc_active, secure_lock}, 16'h0004);
		cmd(ISC_PROGRAM, 16'h1000);
		chk({14'h0000, jcp_ctl_model_i.oe_seen, isc_active}, 16'h0000);
	endtask

	task automatic t_open();
		cmd(ISC_ENABLE, 16'h0001);
		chk({15'h0000, isc_active}, 16'h0001);
		chk(pins(), 16'h0005);
		ir(4'h0);
		chk(q, {12'h000, IR_CAPTURE});
		dr(16'h1234);
		chk(q, 16'h2468);
	endtask

	task automatic t_program();
		rd(7'h10, 16'h10ff);
		cmd(ISC_PROGRAM, 16'h105a);
		chk(pins(), 16'h0001);
		wait_idle();
		chk(pins(), 16'h0005);
		rd(7'h10, 16'h105a);
		// Raising bits by programming fails and latches the error pin low.
		cmd(ISC_PROGRAM, 16'h10ff);
		wait_idle();
		chk(pins(), 16'h0004);
		cmd(ISC_CLEAR, 16'h0000);
		chk(pins(), 16'h0005);
	endtask

	task automatic t_protect();
		cmd(ISC_PROTECT, 16'h0002);
		cmd(ISC_ERASE, 16'h1000);
		wait_idle();
		chk(pins(), 16'h0004);
		rd(7'h10, 16'h105a);
	endtask

	// Device reset mid-cycle; the latched error must survive it.
	task automatic t_abort();
		cmd(ISC_PROGRAM, 16'h2000);
		chk(pins(), 16'h0000);
		dev_rst_n = 1'b0;
		repeat (7) @(negedge clk);
		chk(pins(), 16'h0004);
		dev_rst_n = 1'b1;
		wait_idle();
		chk(pins(), 16'h0004);
	endtask

	task automatic t_secure();
		cmd(ISC_SECURE, 16'h0000);
		chk({15'h0000, secure_lock}, 16'h0001);
		rd(7'h10, 16'h0000);
		cmd(ISC_PROGRAM, 16'h3000);
		chk(pins(), 16'h0004);
		cmd(ISC_CHIP_ERASE, 16'h0000);
		wait_idle();
		chk({15'h0000, secure_lock}, 16'h0000);
		rd(7'h10, 16'h10ff);
	endtask

	task automatic t_release();
		cmd(ISC_DISABLE, 16'h0000);
		chk(pins(), 16'h0006);
		dev_rst_n = 1'b0;
		repeat (4) @(negedge clk);
		dev_rst_n = 1'b1;
		repeat (4) @(negedge clk);
		cmd(ISC_ENABLE, 16'h0003);
		chk(pins(), 16'h000a);
		// The controller keeps the device in reset for the whole program cycle.
		dev_rst_n = 1'b0;
		cmd(ISC_PROGRAM, 16'h1000);
		chk(pins(), 16'h0002);
		wait_idle();
		rd(7'h10, 16'h1000);
		dev_rst_n = 1'b1;
	endtask

	task automatic report_and_stop();
		$display("Comparisons: %0d  mismatches: %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		dev_rst_n = 1'b1;
		gp_stat_out = 1'b1;
		gp_stat_oe_n = 1'b0;
		gp_err_out = 1'b0;
		gp_err_oe_n = 1'b1;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		jcp_ctl_model_i.reset_tap();
		t_closed();
		t_open();
		t_program();
		t_protect();
		t_abort();
		t_secure();
		t_release();
		report_and_stop();
	end

	// About 60 scans of 1.6 us (instruction) or 3.4 us (data) each fit well inside this limit.
	initial begin
		#800000;
		err_total++;
		report_and_stop();
	end
endmodule // jcp_top_tb_top
`default_nettype wire
